// [src/mii_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mii_link_if;
   logic linkClk;        // mii clock, driven by host divider
   logic [3:0] txData;   // transmit nibble
   logic txEnable;       // transmit enable
   logic txErrorLpiRequest;  // low-power idle request
   logic [3:0] rxData;   // receive nibble
   logic rxValid;        // receive data valid
   logic chipReset_n;    // chip reset, active low
   logic indicatorOut;   // indicator pin output value
   logic indicatorOe_n;  // indicator pin output enable, low drives
   logic strapIn;        // level seen on the shared indicator pin
   modport device (input linkClk, txData, txEnable, txErrorLpiRequest, chipReset_n, strapIn,
      output rxData, rxValid, indicatorOut, indicatorOe_n);
   modport host (output linkClk, txData, txEnable, txErrorLpiRequest, chipReset_n,
      input rxData, rxValid, indicatorOut, indicatorOe_n, strapIn);
endinterface
`default_nettype wire

// [src/mii_mac_end.sv]
`timescale 1ns/1ps
`default_nettype none
module mii_mac_end (
   mii_link_if.host link,
   input wire logic clk,              // system clock
   input wire logic sys_rst,          // async reset, active high
   input wire logic phyResetRequest,  // hold device in reset
   input wire logic [3:0] sendData,   // nibble to send, level
   input wire logic sendValid,        // send a nibble
   output logic sendReady,            // nibble taken this cycle
   input wire logic lpiRequest,       // ask for low-power idle
   output logic [3:0] recvData,       // received nibble
   output logic recvValid,            // one-cycle pulse per nibble
   output logic indicatorLevel        // synchronised indicator pin level
);
   ////////////////////////////////////////////////////////////////////////
   // link clock divider
   logic [3:0] divCount, next_divCount;
   logic linkClkQ, next_linkClkQ;
   always_comb begin
      next_divCount = divCount + 4'h1;
      next_linkClkQ = linkClkQ;
      if (divCount == mii_pins_pkg::LINK_HALF_LAST) begin
         next_divCount = 4'h0;
         next_linkClkQ = ~linkClkQ;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // transmit drive: change only on falling link edges, stable at rise
   logic [3:0] txDataQ, next_txDataQ;
   logic txEnQ, next_txEnQ, txErQ, next_txErQ, rstQ, next_rstQ;
   logic fallPulse;
   always_comb begin
      fallPulse = (divCount == mii_pins_pkg::LINK_HALF_LAST) && linkClkQ;
      next_txDataQ = txDataQ;
      next_txEnQ = txEnQ;
      next_txErQ = txErQ;
      next_rstQ = ~phyResetRequest;
      sendReady = fallPulse && sendValid && !lpiRequest;
      if (fallPulse) begin
         next_txEnQ = sendReady;
         next_txDataQ = sendReady ? sendData : 4'h0;
         next_txErQ = lpiRequest && !sendValid;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         divCount <= 4'h0;
         linkClkQ <= 1'b0;
         txDataQ <= 4'h0;
         txEnQ <= 1'b0;
         txErQ <= 1'b0;
         rstQ <= 1'b0;
      end else begin
         divCount <= next_divCount;
         linkClkQ <= next_linkClkQ;
         txDataQ <= next_txDataQ;
         txEnQ <= next_txEnQ;
         txErQ <= next_txErQ;
         rstQ <= next_rstQ;
      end
   end
   assign link.linkClk = linkClkQ;
   assign link.txData = txDataQ;
   assign link.txEnable = txEnQ;
   assign link.txErrorLpiRequest = txErQ;
   assign link.chipReset_n = rstQ;
   ////////////////////////////////////////////////////////////////////////
   // receive: pins pass two flops, then sampled mid link cycle, at the falling edge
   logic [3:0] rxMeta, rxSync;
   logic rxvMeta, rxvSync, ledMeta, ledSync;
   logic [3:0] next_recvData;
   logic next_recvValid;
   always_comb begin
      next_recvData = recvData;
      next_recvValid = 1'b0;
      // sample well after the device's edge, data settled by then
      if (fallPulse && rxvSync) begin
         next_recvData = rxSync;
         next_recvValid = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxMeta <= 4'h0;
         rxSync <= 4'h0;
         rxvMeta <= 1'b0;
         rxvSync <= 1'b0;
         ledMeta <= 1'b1;
         ledSync <= 1'b1;
         recvData <= 4'h0;
         recvValid <= 1'b0;
      end else begin
         rxMeta <= link.rxData;
         rxSync <= rxMeta;
         rxvMeta <= link.rxValid;
         rxvSync <= rxvMeta;
         ledMeta <= link.indicatorOut;
         ledSync <= ledMeta;
         recvData <= next_recvData;
         recvValid <= next_recvValid;
      end
   end
   assign indicatorLevel = ledSync;
endmodule
`default_nettype wire

// [src/mii_phy_end.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - indicator follows two-bit link/activity mode
// - strap level at reset release sets autoneg
// - error input with enable low puts transmit into low-power idle
// - low chip reset input resets device
// - receive nibble changes on link clock
// - receive valid only with valid nibble
// - host drives transmit nibble on link clock
// - transmit data accepted only while enable high
// - high strap means auto-negotiation enabled
module mii_phy_end (
   mii_link_if.device link,
   input wire logic [1:0] ledMode,      // indicator mode field
   input wire logic linkUp,             // line side link status
   input wire logic [3:0] lineRxData,   // nibble from line side
   input wire logic lineRxValid,        // line side has a nibble
   output logic [3:0] lineTxData,       // accepted transmit nibble
   output logic lineTxValid,            // transmit nibble accepted
   output logic lpiActive,              // transmit side in low-power idle
   output logic autonegEnable           // auto-negotiation enable bit
);
   ////////////////////////////////////////////////////////////////////////
   // reset: async assert, released after sync in link domain
   // the pin may rise anywhere in a link cycle, so only its release is
   // retimed; a low pin still stops the device at once
   logic rstMeta;   // first synchroniser stage, may go metastable
   logic rstSync;   // active high internal reset
   // two-flop synchroniser, set straight from the low pin
   always_ff @(posedge link.linkClk or negedge link.chipReset_n) begin
      // pin low: hold everything in reset at once
      if (!link.chipReset_n) begin
         rstMeta <= 1'b1;
         rstSync <= 1'b1;
      end else begin
         rstMeta <= 1'b0;
         rstSync <= rstMeta;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // strap capture: strap pin passes two flops, caught on the first cycle out of reset
   // the synchroniser still holds the level from while the pin was
   // released, so the strap and not the indicator drive lands in the
   // enable bit
   logic strapMeta;           // first stage of the strap synchroniser
   logic strapSync;           // strap level, safe to read
   logic strapTaken;          // strap already latched since reset
   logic next_strapTaken;     // next value of strapTaken
   logic next_autonegEnable;  // next value of autonegEnable
   // strap synchroniser, no reset: it is read only after release
   always_ff @(posedge link.linkClk) begin
      strapMeta <= link.strapIn;
      strapSync <= strapMeta;
   end
   // latch once, then hold until the next reset
   always_comb begin
      next_strapTaken = 1'b1;
      next_autonegEnable = autonegEnable;
      // first cycle after release: take the synchronised strap
      if (!strapTaken) begin
         next_autonegEnable = (strapSync == mii_pins_pkg::STRAP_AN_ON);
      end
   end
   // enable bit reads 0 for as long as reset holds
   always_ff @(posedge link.linkClk or posedge rstSync) begin
      if (rstSync) begin
         strapTaken <= 1'b0;
         autonegEnable <= 1'b0;
      end else begin
         strapTaken <= next_strapTaken;
         autonegEnable <= next_autonegEnable;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // transmit and receive datapath, all on link clock
   // both directions are registered once, so a nibble shows one link
   // cycle after it was presented; the cost is a cycle of latency
   mii_pins_pkg::dev_state_type state;       // transmit side state
   mii_pins_pkg::dev_state_type next_state;  // next transmit side state
   logic [3:0] next_lineTxData;  // nibble to hand to the line side
   logic [3:0] next_rxData;      // nibble to put on the receive pins
   logic next_lineTxValid;       // a nibble is handed over next cycle
   logic next_rxValid;           // receive valid for the next cycle
   logic [3:0] rxDataQ;   // registered receive nibble
   logic rxValidQ;        // registered receive valid
   // next state and next pin values
   always_comb begin
      next_state = state;
      next_lineTxData = lineTxData;
      next_lineTxValid = 1'b0;
      // receive: valid only while a nibble is presented
      // data reads zero between nibbles, so idle pins carry nothing stale
      next_rxValid = lineRxValid;
      next_rxData = lineRxValid ? lineRxData : 4'h0;
      case (state)
         // idle: wait for a nibble or a low-power idle request
         mii_pins_pkg::ST_IDLE: begin
            // enable wins over the request, so data is never dropped here; ST_LPI ignores enable
            if (link.txErrorLpiRequest && !link.txEnable) begin
               next_state = mii_pins_pkg::ST_LPI;
            end else if (link.txEnable) begin
               next_state = mii_pins_pkg::ST_TX;
               next_lineTxData = link.txData;
               next_lineTxValid = 1'b1;
            end
         end
         // sending: pass each nibble on while enable holds
         mii_pins_pkg::ST_TX: begin
            if (link.txEnable) begin
               next_lineTxData = link.txData;
               next_lineTxValid = 1'b1;
            end else begin
               next_state = mii_pins_pkg::ST_IDLE;
            end
         end
         // low-power idle: transmit side quiet
         mii_pins_pkg::ST_LPI: begin
            // leave idle once the request drops
            if (!link.txErrorLpiRequest) begin
               next_state = mii_pins_pkg::ST_IDLE;
            end
         end
         // unused code: recover to idle
         default: next_state = mii_pins_pkg::ST_IDLE;
      endcase
   end
   // registers only; receive pins sit idle at zero during reset
   always_ff @(posedge link.linkClk or posedge rstSync) begin
      if (rstSync) begin
         state <= mii_pins_pkg::ST_IDLE;
         lineTxData <= 4'h0;
         lineTxValid <= 1'b0;
         rxDataQ <= 4'h0;
         rxValidQ <= 1'b0;
      end else begin
         state <= next_state;
         lineTxData <= next_lineTxData;
         lineTxValid <= next_lineTxValid;
         rxDataQ <= next_rxData;
         rxValidQ <= next_rxValid;
      end
   end
   // pins come straight from flops, so they move only on the rising edge
   assign link.rxData = rxDataQ;
   assign link.rxValid = rxValidQ;
   // low-power idle status decoded from the state flop
   assign lpiActive = (state == mii_pins_pkg::ST_LPI);
   ////////////////////////////////////////////////////////////////////////
   // indicator: link level, blinking on activity
   // the blink only advances while traffic flows, so a short burst
   // leaves the pin on; this keeps light traffic from flickering it
   logic [7:0] blinkCount;       // activity cycles in this blink phase
   logic [7:0] next_blinkCount;  // next value of blinkCount
   logic blinkPhase;             // high while the blink holds the pin off
   logic next_blinkPhase;        // next value of blinkPhase
   logic indicator;              // registered pin level
   logic next_indicator;         // next pin level
   logic activity;   // transmit or receive traffic this cycle
   // true for the modes that blink; reserved codes fall in with mode 00
   function automatic logic blinkMode(input logic [1:0] mode);
      blinkMode = (mode != mii_pins_pkg::LED_MODE_LINK_ONLY);
   endfunction
   // blink counter and next pin level
   always_comb begin
      activity = lineTxValid | rxValidQ;
      next_blinkCount = blinkCount;
      next_blinkPhase = blinkPhase;
      // a full count of activity cycles flips the phase
      if (activity) begin
         if (blinkCount == mii_pins_pkg::BLINK_LAST) begin
            next_blinkCount = 8'h00;
            next_blinkPhase = ~blinkPhase;
         end else begin
            next_blinkCount = blinkCount + 8'h01;
         end
      end else begin
         next_blinkCount = 8'h00;
         next_blinkPhase = 1'b0;
      end
      // pin level: off without link, then as the mode asks
      if (!linkUp) begin
         next_indicator = mii_pins_pkg::LED_OFF_LEVEL;
      end else if (!blinkMode(ledMode)) begin
         next_indicator = mii_pins_pkg::LED_ON_LEVEL;
      end else begin
         // mode 00 and reserved codes blink on activity
         next_indicator = mii_pins_pkg::LED_ON_LEVEL ^ blinkPhase;
      end
   end
   // indicator registers; pin reads off during reset
   always_ff @(posedge link.linkClk or posedge rstSync) begin
      if (rstSync) begin
         blinkCount <= 8'h00;
         blinkPhase <= 1'b0;
         indicator <= mii_pins_pkg::LED_OFF_LEVEL;
      end else begin
         blinkCount <= next_blinkCount;
         blinkPhase <= next_blinkPhase;
         indicator <= next_indicator;
      end
   end
   // pin is an input while reset holds so the strap can be read
   // the strap resistor sets the level the pin shows until then
   assign link.indicatorOut = indicator;
   assign link.indicatorOe_n = rstSync;
endmodule
`default_nettype wire

// [src/mii_pins_pkg.sv]
package mii_pins_pkg;
   // indicator mode field, two bits
   localparam logic [1:0] LED_MODE_LINK_ACT = 2'h0;
   localparam logic [1:0] LED_MODE_LINK_ONLY = 2'h1;
   localparam logic [1:0] LED_MODE_RESET = 2'h0;
   // indicator pin levels
   localparam logic LED_ON_LEVEL = 1'h0;
   localparam logic LED_OFF_LEVEL = 1'h1;
   // auto-negotiation enable level on the strap
   localparam logic STRAP_AN_ON = 1'h1;
   // activity blink: link clock cycles per toggle
   localparam int BLINK_TIME_NS = 40000;
   localparam int LINK_PERIOD_NS = 160;
   localparam int BLINK_CYCLES = BLINK_TIME_NS / LINK_PERIOD_NS;
   localparam logic [7:0] BLINK_LAST = 8'(BLINK_CYCLES - 1);
   // host divider: system cycles per link clock half period (200 MHz / 32)
   localparam logic [3:0] LINK_HALF_LAST = 4'hF;
   // device side main states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TX = 2'b01,
      ST_LPI = 2'b10
   } dev_state_type;
endpackage

// [tb/mii_pins_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module mii_pins_monitor (
   input wire logic linkClk,
   input wire logic txEnable,
   input wire logic txErrorLpiRequest,
   input wire logic [3:0] rxData,
   input wire logic rxValid,
   input wire logic chipReset_n,
   input wire logic indicatorOut,
   input wire logic indicatorOe_n
);
   // all checks live in the link domain, gated by the device reset
   default clocking @(posedge linkClk); endclocking
   default disable iff (!chipReset_n);
   // pins seen at the falling link edge; must match at the next rise
   logic [5:0] atFall;
   always_ff @(negedge linkClk) atFall <= {indicatorOut, rxValid, rxData};
   ////////////////////////////////////////////////////////////
   rx_idle_zero_a: assert property (!rxValid |-> rxData == 4'h0)
      else $error("rx nibble not zero while idle");
   rx_data_sync_a: assert property (rxData == atFall[3:0])
      else $error("rx nibble moved off the rising edge");
   rx_valid_sync_a: assert property (rxValid == atFall[4])
      else $error("rx valid moved off the rising edge");
   led_sync_a: assert property (indicatorOut == atFall[5])
      else $error("indicator moved off the rising edge");
   led_off_level_a: assert property (indicatorOe_n |-> indicatorOut)
      else $error("released indicator not at off level");
   led_drive_a: assert property (chipReset_n [*8] |-> !indicatorOe_n)
      else $error("indicator not driven after reset");
   strap_window_a: assert property ($rose(chipReset_n) |-> indicatorOe_n ##1 indicatorOe_n)
      else $error("strap pin driven too early");
   rx_quiet_rel_a: assert property ($rose(chipReset_n) |-> !rxValid [*2])
      else $error("rx valid right after reset");
   ////////////////////////////////////////////////////////////
   cover property (rxValid);
   cover property (txEnable);
   cover property (txErrorLpiRequest && !txEnable);
   cover property (!indicatorOe_n && indicatorOut);
endmodule
`default_nettype wire

// [tb/phy_mii_led_strap_pins_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_mii_led_strap_pins_tb;
   // bench drives, design answers
   logic clk = 1'b0, sys_rst = 1'b1, phyResetRequest = 1'b1, sendValid = 1'b0;
   logic lpiRequest = 1'b0, linkUp = 1'b0, lineRxValid = 1'b0, strapLevel = 1'b0;
   logic sawOff = 1'b0;
   logic [3:0] sendData = 4'h0, lineRxData = 4'h0, recvData, lineTxData;
   logic [1:0] ledMode = 2'h0;
   logic sendReady, recvValid, indicatorLevel, lineTxValid, lpiActive, autonegEnable;
   int errors = 0, total_checks = 0, cycles = 0;
   int txQ[$], rxQ[$]; // expected nibbles per direction
   mii_link_if link ();
   // shared pin: strap level while released, else device drive
   assign link.strapIn = link.indicatorOe_n ? strapLevel : link.indicatorOut;
   always #2.5 clk = ~clk;
   mii_mac_end i_mii_mac_end (.link(link), .clk(clk), .sys_rst(sys_rst),
      .phyResetRequest(phyResetRequest), .sendData(sendData), .sendValid(sendValid),
      .sendReady(sendReady), .lpiRequest(lpiRequest), .recvData(recvData),
      .recvValid(recvValid), .indicatorLevel(indicatorLevel));
   mii_phy_end i_mii_phy_end (.link(link), .ledMode(ledMode), .linkUp(linkUp),
      .lineRxData(lineRxData), .lineRxValid(lineRxValid), .lineTxData(lineTxData),
      .lineTxValid(lineTxValid), .lpiActive(lpiActive), .autonegEnable(autonegEnable));
   mii_pins_monitor i_mii_pins_monitor (.linkClk(link.linkClk), .txEnable(link.txEnable),
      .txErrorLpiRequest(link.txErrorLpiRequest), .rxData(link.rxData),
      .rxValid(link.rxValid), .chipReset_n(link.chipReset_n),
      .indicatorOut(link.indicatorOut), .indicatorOe_n(link.indicatorOe_n));
   ////////////////////////////////////////////////////////////
   task automatic check4(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      check4({3'h0, got}, {3'h0, exp});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // hold a nibble until the host takes it; stays valid for back-to-back
   task automatic send(input logic [3:0] d);
      int k;
      sendData = d;
      sendValid = 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (sendReady !== 1'b1 && k < 80);
      txQ.push_back(d);
      @(negedge clk);
   endtask
   // line side burst, changed at the falling link edge
   task automatic recv(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge link.linkClk);
         lineRxValid = 1'b1;
         lineRxData = 4'($urandom);
         rxQ.push_back(lineRxData);
      end
      @(negedge link.linkClk);
      lineRxValid = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   // scoreboards against the queued model
   // outputs are read mid-cycle, away from the edge that launches them
   always @(negedge link.linkClk) begin
      if (lineTxValid === 1'b1) begin
         check4(lineTxData, 4'(txQ.pop_front()));
      end
   end
   always @(negedge clk) begin
      if (recvValid === 1'b1) begin
         check4(recvData, 4'(rxQ.pop_front()));
      end
      if (indicatorLevel === 1'b1) begin
         sawOff <= 1'b1;
      end
      cycles++;
      // a hang counts as a mismatch
      if (cycles == 80000) begin
         errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(4308));
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      // reset twice: strap low, then high, second one mid-run
      for (int s = 0; s < 2; s++) begin
         phyResetRequest = 1'b1;
         strapLevel = s[0];
         repeat (200) @(negedge clk);
         check1(autonegEnable, 1'b0);
         phyResetRequest = 1'b0;
         repeat (400) @(negedge clk);
         check1(autonegEnable, s[0]);
      end
      for (int i = 0; i < 12; i++) send(4'($urandom));
      // low-power idle refuses the held request; idle starts once it is dropped
      lpiRequest = 1'b1;
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         check1(sendReady, 1'b0);
         if (i == 99) begin
            sendValid = 1'b0;
         end
      end
      check1(lpiActive, 1'b1);
      lpiRequest = 1'b0;
      repeat (100) @(negedge clk);
      check1(lpiActive, 1'b0);
      recv(20);
      // every mode code: off without link, on with link, blink on activity in all modes but 01
      for (int m = 0; m < 4; m++) begin
         @(negedge clk);
         ledMode = 2'(m);
         linkUp = 1'b0;
         repeat (100) @(negedge clk);
         check1(indicatorLevel, 1'b1);
         linkUp = 1'b1;
         repeat (100) @(negedge clk);
         check1(indicatorLevel, 1'b0);
         sawOff = 1'b0;
         recv(270);
         check1(sawOff, m != 1);
      end
      // every nibble sent or received must have come out by now
      repeat (100) @(negedge clk);
      check1(txQ.size() == 0, 1'b1);
      check1(rxQ.size() == 0, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
